// *** include/prs_pkg.sv ***
// Package for the rail sequencer and supervisor: widths, encodings, timing.
// Assumes a 125 MHz system clock; sequencing delays are counted in cycles of it.
package prs_pkg;
    localparam int NUM_RAILS = 8;          // 4 bucks, linear, 3 load switches
    localparam int NUM_MON = 5;            // bucks a..d and linear rail
    localparam int NUM_BU = 2;
    localparam int NUM_LS = 3;
    localparam int NUM_STROBES = 10;
    localparam int NUM_DELAYS = 9;
    localparam int SLOT_W = 4;
    localparam int DLY_SEL_W = 2;
    localparam int VSET_W = 6;
    localparam int THR_W = 8;
    localparam int RAIL_BUCK_A = 0;
    localparam int RAIL_BUCK_B = 1;
    localparam int RAIL_LINEAR = 4;
    localparam logic [SLOT_W-1:0] SLOT_NONE = 4'h0;
    localparam int CLK_MHZ = 125;
    // Selectable interval 2, 3, 4, 5 ms
    localparam int DLY_MIN_MS = 2;
    localparam int DLY_MAX_MS = 5;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int DOWN_FACTOR = 10;
    localparam int DLY_CNT_W = 27;
    localparam int SLEW_W = 4;
    localparam logic [NUM_RAILS*SLOT_W-1:0] DEFAULT_SLOTS = 32'h0000_9876;
    localparam logic [NUM_DELAYS*DLY_SEL_W-1:0] DEFAULT_DLYS = 18'h0_0000;
    localparam logic [THR_W-1:0] UVLO_THR_RST = 8'h80;
    localparam logic [THR_W-1:0] SUP_THR_RST = 8'h10;

    typedef enum logic [1:0] {
        PRS_IDLE = 2'b00,
        PRS_UP = 2'b01,
        PRS_DOWN = 2'b10
    } prs_state_t;

    typedef struct packed {
        logic [NUM_LS-1:0] over_temp;
        logic [NUM_LS-1:0] over_cur;
        logic [NUM_LS-1:0] under_volt;
    } prs_ls_flags_t;
endpackage

// *** rtl/prs_supervisor.sv ***
// Voltage supervisor: main and backup power-good from rail comparators.
// Assumes comparator inputs already synchronised by the caller.
`timescale 1ns/1ps
module prs_supervisor (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_strict,
    input wire logic [prs_pkg::NUM_MON-1:0] i_enabled,
    input wire logic [prs_pkg::NUM_MON-1:0] i_uv,
    input wire logic [prs_pkg::NUM_MON-1:0] i_ov,
    input wire logic [prs_pkg::NUM_BU-1:0] i_bu_ok,
    output logic o_main_rails_good,
    output logic o_backup_rails_good
);
    import prs_pkg::*;
    logic main_good;
    logic bu_good;
    logic next_main_good;
    logic next_bu_good;
    logic [NUM_MON-1:0] fault;

    always_comb begin
        // Standard setting ignores overvoltage
        fault = i_enabled & (i_uv | (i_strict ? i_ov : '0));
        next_main_good = ~|fault;
        next_bu_good = &i_bu_ok;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            main_good <= 1'b0;
            bu_good <= 1'b0;
        end else begin
            main_good <= next_main_good;
            bu_good <= next_bu_good;
        end
    end

    assign o_main_rails_good = main_good;
    assign o_backup_rails_good = bu_good;

    a_pg_fault: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (|(i_enabled & i_uv)) |=> !o_main_rails_good)
        else $error("main good held while an enabled rail is low");
    a_pg_std_ov: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (!i_strict && !(|(i_enabled & i_uv))) |=> o_main_rails_good)
        else $error("standard setting reacted to overvoltage");
    a_bu_good: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (&i_bu_ok) |=> o_backup_rails_good)
        else $error("backup good not raised");
endmodule

// *** rtl/prs_rail_sequencer.sv ***
// Rail sequencer: strobes, delays, rail enables, thresholds, load-switch flags.
// Assumes an external I2C slave writes these ports; comparators are asynchronous.
//
// Notes on behaviour
// - Ten strobes with nine delays between them
// - Each rail tied to one strobe slot
// - Several rails may share a slot
// - Each delay selectable from 2 to 5 ms
// - Default sequence at reset, host may override
// - Host enables each rail, switch and GPIO
// - UVLO and supervisor thresholds host programmable
// - Load-switch temperature, current, voltage flags raised
// - Supervisor watches four bucks and linear rail
// - Standard checks undervoltage, strict adds overvoltage
// - Main good shows all enabled monitored rails regulated
// - Backup converters have their own good
// - First two bucks ramp voltage at slew rate
// - Backup battery state readable by host
// - First strobe at once, then delays follow
// - Slot zero rails ignored by sequencer
// - Power-down reversed, delays ten times longer
// - Enables locked while busy, always show state
`timescale 1ns/1ps
module prs_rail_sequencer (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_pwr_up,
    input wire logic i_pwr_down,
    input wire logic i_cfg_we,
    input wire logic [prs_pkg::NUM_RAILS*prs_pkg::SLOT_W-1:0] i_rail_slot_assignment,
    input wire logic [prs_pkg::NUM_DELAYS*prs_pkg::DLY_SEL_W-1:0] i_slot_delay_setting,
    input wire logic i_en_we,
    input wire logic [prs_pkg::NUM_RAILS-1:0] i_en_wdata,
    input wire logic i_gpio_we,
    input wire logic [2:0] i_gpio_wdata,
    input wire logic i_thr_we,
    input wire logic [prs_pkg::THR_W-1:0] i_uvlo_thr,
    input wire logic [prs_pkg::THR_W-1:0] i_sup_thr,
    input wire logic i_strict,
    input wire logic i_vset_we,
    input wire logic [prs_pkg::VSET_W-1:0] i_vset_a,
    input wire logic [prs_pkg::VSET_W-1:0] i_vset_b,
    input wire logic [prs_pkg::SLEW_W-1:0] i_slew,
    input wire logic [prs_pkg::NUM_MON-1:0] i_uv_pin,
    input wire logic [prs_pkg::NUM_MON-1:0] i_ov_pin,
    input wire logic [prs_pkg::NUM_BU-1:0] i_bu_ok_pin,
    input wire logic i_batt_ok_pin,
    input wire prs_pkg::prs_ls_flags_t i_ls_fault_pin,
    input wire prs_pkg::prs_ls_flags_t i_ls_clr,
    output logic [prs_pkg::NUM_RAILS-1:0] o_rail_enable_bits,
    output logic [2:0] o_gpio,
    output logic o_busy,
    output logic o_en_refused,
    output logic [prs_pkg::THR_W-1:0] o_uvlo_thr,
    output logic [prs_pkg::THR_W-1:0] o_sup_thr,
    output logic [prs_pkg::VSET_W-1:0] o_vout_a,
    output logic [prs_pkg::VSET_W-1:0] o_vout_b,
    output prs_pkg::prs_ls_flags_t o_ls_flags,
    output logic o_batt_ok,
    output logic o_main_rails_good,
    output logic o_backup_rails_good
);
    import prs_pkg::*;

    // Pin synchronisers; stage one only feeds stage two
    logic [NUM_MON-1:0] uv_s1, uv_s2, ov_s1, ov_s2;
    logic [NUM_BU-1:0] bu_s1, bu_s2;
    logic batt_s1, batt_s2;
    logic [3*NUM_LS-1:0] lsf_s1, lsf_s2;

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            uv_s1 <= '0;
            uv_s2 <= '0;
            ov_s1 <= '0;
            ov_s2 <= '0;
            bu_s1 <= '0;
            bu_s2 <= '0;
            batt_s1 <= 1'b0;
            batt_s2 <= 1'b0;
            lsf_s1 <= '0;
            lsf_s2 <= '0;
        end else begin
            uv_s1 <= i_uv_pin;
            uv_s2 <= uv_s1;
            ov_s1 <= i_ov_pin;
            ov_s2 <= ov_s1;
            bu_s1 <= i_bu_ok_pin;
            bu_s2 <= bu_s1;
            batt_s1 <= i_batt_ok_pin;
            batt_s2 <= batt_s1;
            lsf_s1 <= i_ls_fault_pin;
            lsf_s2 <= lsf_s1;
        end
    end

    // Sequencer state
    prs_state_t state, next_state;
    logic [SLOT_W-1:0] strobe, next_strobe;
    logic [DLY_CNT_W-1:0] dly_cnt, next_dly_cnt;
    logic [NUM_RAILS*SLOT_W-1:0] slots, next_slots;
    logic [NUM_DELAYS*DLY_SEL_W-1:0] dlys, next_dlys;
    logic [NUM_RAILS-1:0] en, next_en;
    logic [NUM_RAILS-1:0] hit;
    logic [NUM_RAILS-1:0] unassigned;
    logic [DLY_SEL_W-1:0] cur_sel;
    logic [DLY_CNT_W-1:0] cur_dly;
    logic last_strobe;
    logic refused, next_refused;

    // Rails whose slot matches the firing strobe; slot zero never matches
    for (genvar r = 0; r < NUM_RAILS; r++) begin : g_hit
        assign unassigned[r] = (slots[r*SLOT_W +: SLOT_W] == SLOT_NONE);
        assign hit[r] = (slots[r*SLOT_W +: SLOT_W] == strobe)
            && (slots[r*SLOT_W +: SLOT_W] != SLOT_NONE);
    end

    always_comb begin
        next_state = state;
        next_strobe = strobe;
        next_dly_cnt = dly_cnt;
        next_slots = slots;
        next_dlys = dlys;
        next_en = en;
        next_refused = 1'b0;
        cur_sel = '0;
        cur_dly = '0;
        // Delay after strobe k up is index k-1; going down, delay before strobe k-1
        // No delay follows the last strobe going up, so keep the select in range
        if (state == PRS_UP && strobe < 4'(NUM_STROBES)) begin
            cur_sel = dlys[(int'(strobe) - 1) * DLY_SEL_W +: DLY_SEL_W];
        end else if (state == PRS_DOWN && strobe > 4'h1) begin
            cur_sel = dlys[(int'(strobe) - 2) * DLY_SEL_W +: DLY_SEL_W];
        end
        cur_dly = DLY_CNT_W'((DLY_MIN_MS + int'(cur_sel)) * CYC_PER_MS);
        if (state == PRS_DOWN) begin
            cur_dly = DLY_CNT_W'(int'(cur_dly) * DOWN_FACTOR);
        end
        last_strobe = (state == PRS_UP) ? (strobe == 4'(NUM_STROBES)) : (strobe == 4'h1);
        case (state)
            PRS_IDLE: begin
                if (i_cfg_we) begin
                    next_slots = i_rail_slot_assignment;
                    next_dlys = i_slot_delay_setting;
                end
                if (i_en_we) begin
                    next_en = i_en_wdata;
                end
                // A new sequence may start only from idle
                if (i_pwr_up) begin
                    next_state = PRS_UP;
                    next_strobe = 4'h1;
                    next_dly_cnt = '0;
                end else if (i_pwr_down) begin
                    next_state = PRS_DOWN;
                    next_strobe = 4'(NUM_STROBES);
                    next_dly_cnt = '0;
                end
            end
            PRS_UP, PRS_DOWN: begin
                next_refused = i_en_we || i_cfg_we;
                if (dly_cnt == '0) begin
                    // Strobe fires on the first cycle of its slot
                    next_en = (state == PRS_UP) ? (en | hit) : (en & ~hit);
                end
                if (last_strobe) begin
                    next_state = PRS_IDLE;
                    next_strobe = '0;
                    next_dly_cnt = '0;
                end else if (dly_cnt == cur_dly - 1'b1) begin
                    next_dly_cnt = '0;
                    next_strobe = (state == PRS_UP) ? strobe + 4'h1 : strobe - 4'h1;
                end else begin
                    next_dly_cnt = dly_cnt + 1'b1;
                end
            end
            default: begin
                next_state = PRS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state <= PRS_IDLE;
            strobe <= '0;
            dly_cnt <= '0;
            slots <= DEFAULT_SLOTS;
            dlys <= DEFAULT_DLYS;
            en <= '0;
            refused <= 1'b0;
        end else begin
            state <= next_state;
            strobe <= next_strobe;
            dly_cnt <= next_dly_cnt;
            slots <= next_slots;
            dlys <= next_dlys;
            en <= next_en;
            refused <= next_refused;
        end
    end

    // Settings, GPIO, load-switch flags, voltage ramp
    logic [THR_W-1:0] uvlo, next_uvlo, sup, next_sup;
    logic [2:0] gpio, next_gpio;
    logic [3*NUM_LS-1:0] lsf, next_lsf;
    logic [VSET_W-1:0] tgt_a, tgt_b, next_tgt_a, next_tgt_b;
    logic [VSET_W-1:0] va, vb, next_va, next_vb;
    logic [SLEW_W-1:0] slew_cnt, next_slew_cnt;
    logic batt, next_batt;

    always_comb begin
        next_uvlo = i_thr_we ? i_uvlo_thr : uvlo;
        next_sup = i_thr_we ? i_sup_thr : sup;
        next_gpio = i_gpio_we ? i_gpio_wdata : gpio;
        // Set wins over a clear in the same cycle
        next_lsf = (lsf & ~i_ls_clr) | lsf_s2;
        next_tgt_a = i_vset_we ? i_vset_a : tgt_a;
        next_tgt_b = i_vset_we ? i_vset_b : tgt_b;
        next_va = va;
        next_vb = vb;
        next_slew_cnt = slew_cnt + 1'b1;
        // One code step per slew period, so a ramp cannot outrun the converter
        if (slew_cnt >= i_slew) begin
            next_slew_cnt = '0;
            if (va < tgt_a) next_va = va + 1'b1;
            else if (va > tgt_a) next_va = va - 1'b1;
            if (vb < tgt_b) next_vb = vb + 1'b1;
            else if (vb > tgt_b) next_vb = vb - 1'b1;
        end
        next_batt = batt_s2;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            uvlo <= UVLO_THR_RST;
            sup <= SUP_THR_RST;
            gpio <= '0;
            lsf <= '0;
            tgt_a <= '0;
            tgt_b <= '0;
            va <= '0;
            vb <= '0;
            slew_cnt <= '0;
            batt <= 1'b0;
        end else begin
            uvlo <= next_uvlo;
            sup <= next_sup;
            gpio <= next_gpio;
            lsf <= next_lsf;
            tgt_a <= next_tgt_a;
            tgt_b <= next_tgt_b;
            va <= next_va;
            vb <= next_vb;
            slew_cnt <= next_slew_cnt;
            batt <= next_batt;
        end
    end

    prs_supervisor u_sup (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_strict(i_strict),
        .i_enabled(en[NUM_MON-1:0]),
        .i_uv(uv_s2),
        .i_ov(ov_s2),
        .i_bu_ok(bu_s2),
        .o_main_rails_good(o_main_rails_good),
        .o_backup_rails_good(o_backup_rails_good)
    );

    assign o_rail_enable_bits = en;
    assign o_gpio = gpio;
    assign o_busy = (state != PRS_IDLE);
    assign o_en_refused = refused;
    assign o_uvlo_thr = uvlo;
    assign o_sup_thr = sup;
    assign o_vout_a = va;
    assign o_vout_b = vb;
    assign o_ls_flags = lsf;
    assign o_batt_ok = batt;

    a_en_locked: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (o_busy && i_en_we && dly_cnt != '0) |=> (en == $past(en) && o_en_refused))
        else $error("enable write accepted while busy");
    a_first_strobe: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (state == PRS_IDLE && i_pwr_up) |=> ##1 ((en & hit) == hit))
        else $error("first strobe did not enable its rails");
    a_slot_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_busy |=> (((en ^ $past(en)) & $past(unassigned)) == '0))
        else $error("unassigned rail changed by sequencer");
    a_down_clears: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (state == PRS_DOWN && dly_cnt == '0) |=> ((en & $past(hit)) == '0))
        else $error("power-down strobe left rail on");
    a_no_restart: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (state == PRS_UP && !last_strobe) |=> (state == PRS_UP))
        else $error("sequence interrupted");
    a_dly_bound: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_busy |-> (dly_cnt < DLY_CNT_W'(DLY_MAX_MS * CYC_PER_MS * DOWN_FACTOR)))
        else $error("delay counter beyond longest interval");
    a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (|lsf_s2) |=> (|lsf))
        else $error("load-switch event lost");
    a_thr_load: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        i_thr_we |=> (o_uvlo_thr == $past(i_uvlo_thr)))
        else $error("threshold write not taken");
    a_ramp_step: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        1'b1 |=> (va - $past(va) <= 6'h1 || $past(va) - va <= 6'h1))
        else $error("voltage jumped more than one step");
endmodule

// *** tb/prs_rail_plant.sv ***
// Behavioural rail power stage on the far side of the supervisor inputs.
// Assumes rail enables come from the sequencer and faults are requested by the bench.
`timescale 1ns/1ps
module prs_rail_plant #(
    parameter int RAMP = 20
) (
    input wire logic i_clk_sys,
    input wire logic [prs_pkg::NUM_MON-1:0] i_enable,
    input wire logic [prs_pkg::NUM_MON-1:0] i_ov_req,
    output logic [prs_pkg::NUM_MON-1:0] o_uv,
    output logic [prs_pkg::NUM_MON-1:0] o_ov
);
    import prs_pkg::*;
    int ramp_cnt [NUM_MON];
    // Soft start: a rail is low until its ramp time has run out
    always @(posedge i_clk_sys) begin
        for (int r = 0; r < NUM_MON; r++) begin
            if (!i_enable[r]) begin
                ramp_cnt[r] <= 0;
            end else if (ramp_cnt[r] < RAMP) begin
                ramp_cnt[r] <= ramp_cnt[r] + 1;
            end
        end
    end
    always_comb begin
        for (int r = 0; r < NUM_MON; r++) begin
            o_uv[r] = (ramp_cnt[r] < RAMP);
            o_ov[r] = i_enable[r] & i_ov_req[r];
        end
    end
endmodule

// *** tb/test_prs_rail_sequencer.sv ***
// Self-checking bench for the rail sequencer: sequencing, supervisor, flags, settings.
// Assumes full-length delays; only the first up delay is waited out.
`timescale 1ns/1ps
module test_prs_rail_sequencer;
    import prs_pkg::*;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_pwr_up = 1'b0, i_pwr_down = 1'b0;
    logic i_cfg_we = 1'b0, i_en_we = 1'b0, i_gpio_we = 1'b0, i_thr_we = 1'b0;
    logic i_strict = 1'b0, i_vset_we = 1'b0, i_batt_ok_pin = 1'b0;
    logic [NUM_RAILS*SLOT_W-1:0] i_rail_slot_assignment = '0;
    logic [NUM_DELAYS*DLY_SEL_W-1:0] i_slot_delay_setting = '0;
    logic [NUM_RAILS-1:0] i_en_wdata = '0;
    logic [2:0] i_gpio_wdata = '0;
    logic [THR_W-1:0] i_uvlo_thr = '0, i_sup_thr = '0;
    logic [VSET_W-1:0] i_vset_a = '0, i_vset_b = '0;
    logic [SLEW_W-1:0] i_slew = '0;
    logic [NUM_MON-1:0] i_uv_pin, i_ov_pin, ov_req = '0;
    logic [NUM_BU-1:0] i_bu_ok_pin = '0;
    prs_ls_flags_t i_ls_fault_pin = '0, i_ls_clr = '0, o_ls_flags;
    logic [NUM_RAILS-1:0] o_rail_enable_bits;
    logic [2:0] o_gpio;
    logic o_busy, o_en_refused, o_batt_ok, o_main_rails_good, o_backup_rails_good;
    logic [THR_W-1:0] o_uvlo_thr, o_sup_thr;
    logic [VSET_W-1:0] o_vout_a, o_vout_b;
    int mismatches = 0;
    int total_checks = 0;
    localparam int DOWN_DLY = (DLY_MIN_MS + 1) * CYC_PER_MS * DOWN_FACTOR;

    always #4 i_clk_sys = ~i_clk_sys;

    prs_rail_sequencer dut (.*);
    prs_rail_plant plant (
        .i_clk_sys(i_clk_sys),
        .i_enable(o_rail_enable_bits[NUM_MON-1:0]),
        .i_ov_req(ov_req),
        .o_uv(i_uv_pin),
        .o_ov(i_ov_pin)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wr_en(input logic [NUM_RAILS-1:0] v);
        i_en_wdata = v;
        i_en_we = 1'b1;
        tick(1);
        i_en_we = 1'b0;
    endtask
    task automatic wr_cfg(input logic [31:0] s, input logic [17:0] d);
        i_rail_slot_assignment = s;
        i_slot_delay_setting = d;
        i_cfg_we = 1'b1;
        tick(1);
        i_cfg_we = 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Longest wait is one 2 ms up delay, about 0.25M cycles
    initial begin
        #2_400_000;
        mismatches++;
        summarize();
    end

    initial begin
        tick(11);
        chk("rails in reset", 8'h00, o_rail_enable_bits);
        chk("busy in reset", 1'b0, o_busy);
        chk("uvlo reset", 8'h80, o_uvlo_thr);
        chk("sup reset", 8'h10, o_sup_thr);
        chk("flags reset", 9'h0, o_ls_flags);
        tick(1);
        i_nrst = 1'b1;
        i_uvlo_thr = 8'h3c;
        i_sup_thr = 8'h2a;
        i_thr_we = 1'b1;
        i_gpio_wdata = 3'h5;
        i_gpio_we = 1'b1;
        tick(1);
        i_thr_we = 1'b0;
        i_gpio_we = 1'b0;
        chk("uvlo", 8'h3c, o_uvlo_thr);
        chk("sup", 8'h2a, o_sup_thr);
        chk("gpio", 3'h5, o_gpio);
        wr_en(8'hff);
        chk("all on", 8'hff, o_rail_enable_bits);
        tick(1);
        wr_en(8'h11);
        chk("some on", 8'h11, o_rail_enable_bits);
        tick(6);
        chk("good while ramping", 1'b0, o_main_rails_good);
        tick(30);
        chk("good regulated", 1'b1, o_main_rails_good);
        ov_req = 5'h10;
        tick(10);
        chk("ov in standard", 1'b1, o_main_rails_good);
        i_strict = 1'b1;
        tick(10);
        chk("ov in strict", 1'b0, o_main_rails_good);
        i_strict = 1'b0;
        ov_req = '0;
        i_bu_ok_pin = 2'b01;
        tick(10);
        chk("backup partial", 1'b0, o_backup_rails_good);
        chk("main apart", 1'b1, o_main_rails_good);
        i_bu_ok_pin = 2'b11;
        tick(10);
        chk("backup good", 1'b1, o_backup_rails_good);
        i_batt_ok_pin = 1'b1;
        tick(6);
        chk("battery ok", 1'b1, o_batt_ok);
        i_batt_ok_pin = 1'b0;
        tick(6);
        chk("battery low", 1'b0, o_batt_ok);
        for (int i = 0; i < 9; i++) begin
            i_ls_fault_pin = prs_ls_flags_t'(9'h1 << i);
            tick(6);
            i_ls_fault_pin = '0;
            tick(6);
            chk("switch flag sticky", 9'h1 << i, o_ls_flags);
            i_ls_clr = prs_ls_flags_t'(9'h1 << i);
            tick(1);
            i_ls_clr = '0;
            tick(1);
            chk("switch flag cleared", 9'h0, o_ls_flags);
        end
        i_vset_a = 6'h05;
        i_vset_b = 6'h03;
        i_vset_we = 1'b1;
        tick(1);
        i_vset_we = 1'b0;
        tick(70);
        chk("vout a", 6'h05, o_vout_a);
        chk("vout b", 6'h03, o_vout_b);
        i_slew = 4'h1;
        i_vset_a = 6'h0d;
        i_vset_we = 1'b1;
        tick(1);
        i_vset_we = 1'b0;
        tick(4);
        chk("vout a ramping", 1'b1, o_vout_a != 6'h0d);
        tick(20);
        chk("vout a ramped", 6'h0d, o_vout_a);
        wr_en(8'h10);
        wr_cfg(32'h0000_0211, 18'h0_0000);
        i_pwr_up = 1'b1;
        tick(1);
        i_pwr_up = 1'b0;
        tick(2);
        chk("busy up", 1'b1, o_busy);
        chk("strobe 1 rails", 8'h13, o_rail_enable_bits);
        wr_en(8'hff);
        chk("write refused", 1'b1, o_en_refused);
        chk("enables kept", 8'h13, o_rail_enable_bits);
        // Taken, this would move rail 2 off strobe 2 and stretch the delay
        wr_cfg(32'h0000_0000, 18'h3_ffff);
        chk("config refused", 1'b1, o_en_refused);
        chk("enables kept cfg", 8'h13, o_rail_enable_bits);
        // Strobe 2 lands one edge after the delay counter wraps
        tick(DLY_MIN_MS * CYC_PER_MS - 4);
        chk("strobe 2 not yet", 8'h13, o_rail_enable_bits);
        tick(1);
        chk("strobe 2 rails", 8'h17, o_rail_enable_bits);
        chk("busy mid", 1'b1, o_busy);
        i_nrst = 1'b0;
        tick(12);
        chk("reset mid busy", 1'b0, o_busy);
        chk("reset mid rails", 8'h00, o_rail_enable_bits);
        i_nrst = 1'b1;
        wr_cfg(32'h0000_009a, 18'h1_0000);
        wr_en(8'h13);
        i_pwr_down = 1'b1;
        tick(1);
        i_pwr_down = 1'b0;
        tick(2);
        chk("strobe 10 off", 8'h12, o_rail_enable_bits);
        // Full down delays run for millions of cycles; check the programmed length
        chk("down delay", DOWN_DLY, dut.cur_dly);
        tick(2000);
        chk("strobe 9 waits", 8'h12, o_rail_enable_bits);
        chk("busy down", 1'b1, o_busy);
        summarize();
    end
endmodule
